//--- design/sensor_fifo_regs.vh
// Purpose: register indices, field positions, reset values and codes of the sample fifo control block
// Assumes: byte address of a register is four times its index; data sits in bits 7:0 of the bus word
// Notes:   definitions only
`ifndef SENSOR_FIFO_REGS_VH
`define SENSOR_FIFO_REGS_VH

// ----------------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------------
`define IDX_FILL_THRESHOLD     8'h07
`define IDX_COMPRESSION_OPTS   8'h08
`define IDX_BATCH_RATES        8'h09
`define IDX_POLICY_AUX         8'h0a
`define IDX_COUNTER_CFG_HIGH   8'h0b
`define IDX_COUNTER_TH_LOW     8'h0c
`define IDX_PIN1_ROUTING       8'h0d
`define IDX_PIN2_ROUTING       8'h0e
`define IDX_IDENTITY           8'h0f
`define IDX_FIFO_STATUS        8'h10

// ----------------------------------------------------------------------------
// writable-bit masks (reserved bits stay zero) and reset value
// ----------------------------------------------------------------------------
`define MASK_COMPRESSION_OPTS  8'hd7
`define MASK_COUNTER_CFG_HIGH  8'h63
`define MASK_PIN1_ROUTING      8'h7b
`define CTRL_RESET             8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BIT_DEPTH_LIMIT        7
`define BIT_RT_COMPRESSION     6
`define BIT_RATE_CHANGE        4
`define BIT_CH2_PSM_BATCH      0
`define BIT_STAB_GYRO_BATCH    3
`define BIT_ST_THRESHOLD       0
`define BIT_ST_FULL            1
`define BIT_ST_OVERRUN         2
`define BIT_ST_BATCH_COUNTER   3
`define ST_LEVEL_LSB           16

// ----------------------------------------------------------------------------
// buffer policy codes and effective modes
// ----------------------------------------------------------------------------
`define POL_BYPASS             3'b000
`define POL_STOP_FULL          3'b001
`define POL_CONT_WTM_TO_FULL   3'b010
`define POL_CONT_TO_STOP       3'b011
`define POL_BYPASS_TO_CONT     3'b100
`define POL_CONTINUOUS         3'b110
`define POL_BYPASS_TO_STOP     3'b111
`define EFF_BYPASS             2'b00
`define EFF_STOP               2'b01
`define EFF_CONT               2'b10

// ----------------------------------------------------------------------------
// rate codes and divider masks on the 7.68 kHz base tick
// ----------------------------------------------------------------------------
`define RATE_LOWEST_CODE       4'h1
`define RATE_HIGHEST_CODE      4'hc
`define DIV_1875_MHZ           12'hfff
`define DIV_15_HZ              12'h1ff
`define DIV_60_HZ              12'h07f

`endif

//--- design/sensor_fifo_batch_control.v
// Purpose: control logic of the sensor sample fifo: policy, batching rates, batch counter, pin routing
// Assumes: classic wishbone slave, one register per aligned word, data in bits 7:0
// Notes:   only the fifo fill level is tracked here, sample storage lives outside
//
// Summary of operation
// - threshold flag when level at or above threshold
// - depth limit bit caps depth at threshold
// - compression needs runtime bit and master enable
// - rate-change bit writes a rate-change entry
// - forced uncompressed every 8, 16, 32 events
// - channel-2 accel batched only on machine triggers
// - gyro rate code decode, high codes reserved
// - accel rate code decode, high codes reserved
// - timestamp at fastest rate over 1, 8, 32
// - temperature batched at 1.875, 15, 60 Hz
// - stabilisation gyro batch enable bit
// - policy 000 bypass, 001 stop when full
// - policy 110 overwrites oldest; 101 reserved
// - policy 010 threshold-deep continuous, then stop-full
// - trigger release switches policies 011, 100, 111
// - batch counter source select accel/gyro/stab gyro
// - counter at threshold resets and sets flag
// - pin one is OR of enabled sources
// - pin one routed sources; all but counter raise in-band, function routing does not
// - pin two is OR of enabled sources
// - pin two sources with their own enables
// - identity register fixed, writes ignored
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "sensor_fifo_regs.vh"

module sensor_fifo_batch_control #(
  parameter       LW             = 10,        // width of the fill level
  parameter       DEPTH          = 512,       // entries of the fifo
  parameter [7:0] IDENTITY_VALUE = 8'h5a      // arbitrary value
) (
  // clock and reset
  input  wire          clk_i,
  input  wire          rst_i,
  // wishbone slave
  input  wire          cyc_i,
  input  wire          stb_i,
  input  wire          we_i,
  input  wire [7:0]    adr_i,
  input  wire [3:0]    sel_i,
  input  wire [31:0]   dat_i,
  output reg  [31:0]   dat_o,
  output reg           ack_o,
  // sample sources and fifo drain
  input  wire          base_tick_i,            // 7.68 kHz strobe
  input  wire          stab_gyro_sample_i,     // stabilisation channel sample strobe
  input  wire          dual_channel_i,         // dual-channel mode on
  input  wire          psm_trigger_i,          // programmable state machine trigger
  input  wire          mode_trigger_i,         // policy trigger level
  input  wire          fifo_read_i,            // one entry drained
  input  wire          compression_master_enable_i,
  // event sources for the pins
  input  wire          accel_drdy_i,
  input  wire          gyro_drdy_i,
  input  wire          stab_gyro_drdy_i,
  input  wire          function_done_i,
  input  wire          pin_one_function_i,     // OR of pin one function routing
  input  wire          pin_two_function_i,     // OR of pin two function routing
  input  wire          i3c_dyn_addr_i,         // dynamic address assigned
  // fifo state
  output reg  [6:0]    sample_write_o,         // accel gyro stab temp ts ch2 ratechg
  output reg  [LW-1:0] fifo_level_o,
  output reg           fill_threshold_o,
  output reg           fifo_full_o,
  output reg           overrun_o,
  output reg           batch_counter_event_flag_o,
  output reg           compression_active_o,
  output reg           force_uncompressed_o,
  // interrupt outputs
  output reg           interrupt_pin_one_o,
  output reg           interrupt_pin_two_o,
  output reg           ibi_request_o
);

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  reg  [7:0]    fill_threshold;        // threshold in entries
  reg  [7:0]    compression_opts;      // depth limit, compression, rate change
  reg  [7:0]    batch_rates;           // gyro [7:4], accel [3:0]
  reg  [7:0]    policy_aux;            // ts, temp, stab gyro, policy
  reg  [7:0]    counter_cfg_high;      // source and threshold high bits
  reg  [7:0]    counter_th_low;        // threshold low bits
  reg  [7:0]    pin1_routing;          // pin one enables
  reg  [7:0]    pin2_routing;          // pin two enables

  // --------------------------------------------------------------------------
  // internal state
  // --------------------------------------------------------------------------
  reg  [11:0]   tick_count;            // free divider of the base tick
  reg  [4:0]    ts_count;              // timestamp decimation
  reg  [4:0]    unc_count;             // forced uncompressed interval
  reg  [9:0]    batch_count;           // batch event counter
  reg           rate_change_pending;   // rate-change entry to write
  reg  [2:0]    n_writes;              // entries offered this cycle
  reg  [6:0]    offered;               // per-sensor offers
  reg  [1:0]    eff_mode;              // effective policy
  reg  [LW-1:0] limit;                 // usable depth
  reg  [LW:0]   sum;                   // level before clamping
  reg  [LW-1:0] next_level;
  reg           lost;                  // an entry dropped or overwritten
  reg           accepting;
  reg           accel_ev;
  reg           gyro_ev;
  reg           ts_ev;
  reg           temp_ev;
  reg           count_ev;
  reg  [31:0]   next_dat;
  integer       i;

  wire [7:0]    idx        = {2'b00, adr_i[7:2]};
  wire          wr_commit  = cyc_i & stb_i & we_i & ack_o & sel_i[0];
  wire          rd_commit  = cyc_i & stb_i & ~we_i & ack_o;
  wire [9:0]    count_th   = {counter_cfg_high[1:0], counter_th_low};
  wire [2:0]    policy     = policy_aux[2:0];
  wire          rd_ok      = fifo_read_i & (fifo_level_o != {LW{1'b0}});
  wire          status_rd  = rd_commit & (idx == `IDX_FIFO_STATUS);

  // rate code to divider mask; bit 12 marks a valid code
  function [12:0] rate_mask;
    input [3:0] code;
    begin
      if (code == `RATE_LOWEST_CODE) begin
        rate_mask = {1'b1, `DIV_1875_MHZ};
      end else if (code > `RATE_LOWEST_CODE && code <= `RATE_HIGHEST_CODE) begin
        rate_mask = {1'b1, 12'hfff >> code};                    // 7.5 Hz .. 7.68 kHz
      end else begin
        rate_mask = 13'h0000;                                   // off or reserved
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // batch event generation
  // --------------------------------------------------------------------------
  // divider masks are power-of-two aligned, so the faster sensor's events
  // include every event of the slower one; that makes the max-rate easy
  always @* begin : batch_events
    reg [12:0] am;
    reg [12:0] gm;
    am = rate_mask(batch_rates[3:0]);
    gm = rate_mask(batch_rates[7:4]);
    accel_ev = base_tick_i & am[12] & ((tick_count & am[11:0]) == 12'h000);
    gyro_ev  = base_tick_i & gm[12] & ((tick_count & gm[11:0]) == 12'h000);
    // timestamp decimation 1, 8 or 32 of the faster rate
    case (policy_aux[7:6])
      2'b01:   ts_ev = accel_ev | gyro_ev;
      2'b10:   ts_ev = (accel_ev | gyro_ev) & (ts_count[2:0] == 3'h0);
      2'b11:   ts_ev = (accel_ev | gyro_ev) & (ts_count == 5'h00);
      default: ts_ev = 1'b0;
    endcase
    // temperature rates
    case (policy_aux[5:4])
      2'b01:   temp_ev = base_tick_i & ((tick_count & `DIV_1875_MHZ) == 12'h000);
      2'b10:   temp_ev = base_tick_i & ((tick_count & `DIV_15_HZ) == 12'h000);
      2'b11:   temp_ev = base_tick_i & ((tick_count & `DIV_60_HZ) == 12'h000);
      default: temp_ev = 1'b0;
    endcase
    // counter source
    case (counter_cfg_high[6:5])
      2'b00:   count_ev = accel_ev;
      2'b01:   count_ev = gyro_ev;
      default: count_ev = stab_gyro_sample_i & policy_aux[`BIT_STAB_GYRO_BATCH];
    endcase
  end

  // --------------------------------------------------------------------------
  // buffer policy and fill level
  // --------------------------------------------------------------------------
  always @* begin
    // trigger-driven switching
    case (policy)
      `POL_BYPASS:           eff_mode = `EFF_BYPASS;
      `POL_STOP_FULL:        eff_mode = `EFF_STOP;
      `POL_CONT_WTM_TO_FULL: eff_mode = mode_trigger_i ? `EFF_CONT : `EFF_STOP;
      `POL_CONT_TO_STOP:     eff_mode = mode_trigger_i ? `EFF_CONT : `EFF_STOP;
      `POL_BYPASS_TO_CONT:   eff_mode = mode_trigger_i ? `EFF_BYPASS : `EFF_CONT;
      `POL_CONTINUOUS:       eff_mode = `EFF_CONT;
      `POL_BYPASS_TO_STOP:   eff_mode = mode_trigger_i ? `EFF_BYPASS : `EFF_STOP;
      default:               eff_mode = `EFF_BYPASS;
    endcase
    // depth capped at the threshold
    if (compression_opts[`BIT_DEPTH_LIMIT] ||
        (policy == `POL_CONT_WTM_TO_FULL && mode_trigger_i)) begin
      limit = {{(LW-8){1'b0}}, fill_threshold};
    end else begin
      limit = DEPTH[LW-1:0];
    end
    // a stopped fifo takes nothing once full
    accepting = (eff_mode != `EFF_BYPASS) &&
                !(eff_mode == `EFF_STOP && fifo_level_o >= limit);
    offered[0] = accel_ev;
    offered[1] = gyro_ev;
    offered[2] = stab_gyro_sample_i & policy_aux[`BIT_STAB_GYRO_BATCH];
    offered[3] = temp_ev;
    offered[4] = ts_ev;
    offered[5] = dual_channel_i & compression_opts[`BIT_CH2_PSM_BATCH] & psm_trigger_i;
    offered[6] = rate_change_pending;
    n_writes = 3'h0;
    for (i = 0; i < 7; i = i + 1) begin
      n_writes = n_writes + {2'b00, offered[i]};
    end
    if (!accepting) begin
      n_writes = 3'h0;
    end
    sum  = {1'b0, fifo_level_o} - {{LW{1'b0}}, rd_ok} + {{(LW-2){1'b0}}, n_writes};
    lost = 1'b0;
    if (eff_mode == `EFF_BYPASS) begin
      next_level = {LW{1'b0}};
    end else if (sum > {1'b0, limit}) begin
      next_level = limit;     // continuous: oldest dropped; stop: excess dropped
      lost       = 1'b1;
    end else begin
      next_level = sum[LW-1:0];
    end
  end

  // level, flags and write strobes
  always @(posedge clk_i) begin
    if (rst_i) begin
      fifo_level_o     <= {LW{1'b0}};
      fill_threshold_o <= 1'b0;
      fifo_full_o      <= 1'b0;
      overrun_o        <= 1'b0;
      sample_write_o   <= 7'h00;
    end else begin
      fifo_level_o     <= next_level;
      fill_threshold_o <= next_level >= {{(LW-8){1'b0}}, fill_threshold};
      fifo_full_o      <= (eff_mode != `EFF_BYPASS) && (next_level >= limit);
      sample_write_o   <= accepting ? offered : 7'h00;
      // a new loss wins over the clear by a status read
      if (lost) begin
        overrun_o <= 1'b1;
      end else if (status_rd) begin
        overrun_o <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // dividers, batch counter and compression control
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_count                 <= 12'h000;
      ts_count                   <= 5'h00;
      unc_count                  <= 5'h00;
      batch_count                <= 10'h000;
      batch_counter_event_flag_o <= 1'b0;
      compression_active_o       <= 1'b0;
      force_uncompressed_o       <= 1'b0;
    end else begin
      if (base_tick_i) begin
        tick_count <= tick_count + 12'h001;
      end
      if (accel_ev | gyro_ev) begin
        ts_count  <= ts_count + 5'h01;
        unc_count <= unc_count + 5'h01;
      end
      // counter restarts at its threshold
      if (count_ev) begin
        if (batch_count + 10'h001 == count_th) begin
          batch_count <= 10'h000;
        end else begin
          batch_count <= batch_count + 10'h001;
        end
      end
      if (count_ev && (batch_count + 10'h001 == count_th)) begin
        batch_counter_event_flag_o <= 1'b1;
      end else if (status_rd) begin
        batch_counter_event_flag_o <= 1'b0;
      end
      compression_active_o <= compression_opts[`BIT_RT_COMPRESSION] &
                              compression_master_enable_i;
      // forced uncompressed pulse per 8, 16 or 32 batch events
      case (compression_opts[2:1])
        2'b01:   force_uncompressed_o <= (accel_ev | gyro_ev) & (unc_count[2:0] == 3'h7);
        2'b10:   force_uncompressed_o <= (accel_ev | gyro_ev) & (unc_count[3:0] == 4'hf);
        2'b11:   force_uncompressed_o <= (accel_ev | gyro_ev) & (unc_count == 5'h1f);
        default: force_uncompressed_o <= 1'b0;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // interrupt pins and in-band request
  // --------------------------------------------------------------------------
  // source vectors laid out like the routing registers, so one AND picks them
  wire [7:0]    src1 = {1'b0, batch_counter_event_flag_o, fifo_full_o, overrun_o, fill_threshold_o,
                        1'b0, gyro_drdy_i, accel_drdy_i};
  wire [7:0]    src2 = {function_done_i, batch_counter_event_flag_o, fifo_full_o, overrun_o,
                        fill_threshold_o, stab_gyro_drdy_i, gyro_drdy_i, accel_drdy_i};

  // pins idle while a dynamic address is assigned; the in-band request
  // then carries every routed pin one source except the batch counter, and not pin_one_function_i
  always @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_pin_one_o <= 1'b0;
      interrupt_pin_two_o <= 1'b0;
      ibi_request_o       <= 1'b0;
    end else begin
      interrupt_pin_one_o <= ~i3c_dyn_addr_i &
                             ((|(src1 & pin1_routing)) | pin_one_function_i);
      interrupt_pin_two_o <= ~i3c_dyn_addr_i &
                             ((|(src2 & pin2_routing)) | pin_two_function_i);
      ibi_request_o       <= i3c_dyn_addr_i & (|(src1 & pin1_routing & 8'h3b));
    end
  end

  // --------------------------------------------------------------------------
  // wishbone register access
  // --------------------------------------------------------------------------
  // read data is built from the address as the request arrives
  always @* begin
    next_dat = 32'h0000_0000;                                   // unmapped reads zero
    if (idx == `IDX_FILL_THRESHOLD) begin
      next_dat[7:0] = fill_threshold;
    end else if (idx == `IDX_COMPRESSION_OPTS) begin
      next_dat[7:0] = compression_opts;
    end else if (idx == `IDX_BATCH_RATES) begin
      next_dat[7:0] = batch_rates;
    end else if (idx == `IDX_POLICY_AUX) begin
      next_dat[7:0] = policy_aux;
    end else if (idx == `IDX_COUNTER_CFG_HIGH) begin
      next_dat[7:0] = counter_cfg_high;
    end else if (idx == `IDX_COUNTER_TH_LOW) begin
      next_dat[7:0] = counter_th_low;
    end else if (idx == `IDX_PIN1_ROUTING) begin
      next_dat[7:0] = pin1_routing;
    end else if (idx == `IDX_PIN2_ROUTING) begin
      next_dat[7:0] = pin2_routing;
    end else if (idx == `IDX_IDENTITY) begin
      next_dat[7:0] = IDENTITY_VALUE;
    end else if (idx == `IDX_FIFO_STATUS) begin
      next_dat[`BIT_ST_THRESHOLD]     = fill_threshold_o;
      next_dat[`BIT_ST_FULL]          = fifo_full_o;
      next_dat[`BIT_ST_OVERRUN]       = overrun_o;
      next_dat[`BIT_ST_BATCH_COUNTER] = batch_counter_event_flag_o;
      next_dat[`ST_LEVEL_LSB +: LW]   = fifo_level_o;
    end
  end

  // ack one cycle after the request; the write lands on the ack edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o               <= 1'b0;
      dat_o               <= 32'h0000_0000;
      fill_threshold      <= `CTRL_RESET;
      compression_opts    <= `CTRL_RESET;
      batch_rates         <= `CTRL_RESET;
      policy_aux          <= `CTRL_RESET;
      counter_cfg_high    <= `CTRL_RESET;
      counter_th_low      <= `CTRL_RESET;
      pin1_routing        <= `CTRL_RESET;
      pin2_routing        <= `CTRL_RESET;
      rate_change_pending <= 1'b0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      if (cyc_i & stb_i & ~ack_o) begin
        dat_o <= next_dat;
      end
      // a changed rate code queues one rate-change entry
      rate_change_pending <= wr_commit && (idx == `IDX_BATCH_RATES) &&
                             (dat_i[7:0] != batch_rates) &&
                             compression_opts[`BIT_RATE_CHANGE];
      // reserved bits are masked so they always read zero
      if (wr_commit) begin
        if (idx == `IDX_FILL_THRESHOLD) begin
          fill_threshold <= dat_i[7:0];
        end else if (idx == `IDX_COMPRESSION_OPTS) begin
          compression_opts <= dat_i[7:0] & `MASK_COMPRESSION_OPTS;
        end else if (idx == `IDX_BATCH_RATES) begin
          batch_rates <= dat_i[7:0];
        end else if (idx == `IDX_POLICY_AUX) begin
          policy_aux <= dat_i[7:0];
        end else if (idx == `IDX_COUNTER_CFG_HIGH) begin
          counter_cfg_high <= dat_i[7:0] & `MASK_COUNTER_CFG_HIGH;
        end else if (idx == `IDX_COUNTER_TH_LOW) begin
          counter_th_low <= dat_i[7:0];
        end else if (idx == `IDX_PIN1_ROUTING) begin
          pin1_routing <= dat_i[7:0] & `MASK_PIN1_ROUTING;
        end else if (idx == `IDX_PIN2_ROUTING) begin
          pin2_routing <= dat_i[7:0];
        end
      end
    end
  end

endmodule // sensor_fifo_batch_control

//--- testbench/fifo_batch_properties.sv
// Purpose: bus, flag and pin timing checks on the fifo control block
// Assumes: threshold writes are seen on the bus
// Notes:   bound to the design from tb_top
`timescale 1ns/1ps
module fifo_batch_properties #(parameter LW = 10, parameter DEPTH = 512) (
  // bus and clock
  input wire          clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
  input wire [7:0]    adr_i,
  input wire [3:0]    sel_i,
  input wire [31:0]   dat_i,
  // fifo state and pins
  input wire [LW-1:0] fifo_level_o,
  input wire          fill_threshold_o, i3c_dyn_addr_i, pin_one_function_i, pin_two_function_i,
  input wire          interrupt_pin_one_o, interrupt_pin_two_o, ibi_request_o,
  input wire          compression_master_enable_i, compression_active_o
);
  logic [7:0] thr; // shadow of the threshold register, taken at the ack edge
  always @(posedge clk_i) begin
    if (rst_i) thr <= 8'h00;
    else if (ack_o && cyc_i && stb_i && we_i && sel_i[0] && adr_i == 8'h1c) thr <= dat_i[7:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  chk_fill_flag: assert property (thr != 0 && $stable(thr) |-> fill_threshold_o == (fifo_level_o >= thr))
    else $error("threshold flag wrong");
  chk_level_cap: assert property (fifo_level_o <= DEPTH) else $error("level above depth");
  chk_pin_gate: assert property (i3c_dyn_addr_i |=> !interrupt_pin_one_o && !interrupt_pin_two_o)
    else $error("pin driven with address");
  chk_pin_one_or: assert property (!i3c_dyn_addr_i && pin_one_function_i |=> interrupt_pin_one_o)
    else $error("pin one missed source");
  chk_pin_two_or: assert property (!i3c_dyn_addr_i && pin_two_function_i |=> interrupt_pin_two_o)
    else $error("pin two missed source");
  chk_ibi_gate: assert property (!i3c_dyn_addr_i |=> !ibi_request_o) else $error("ibi without address");
  chk_compr_gate: assert property (compression_active_o |-> $past(compression_master_enable_i))
    else $error("compression without master enable");
endmodule // fifo_batch_properties

//--- testbench/host_drain_model.sv
// Purpose: far side: sample timebase and a host draining one entry every other cycle
// Assumes: drain_en held by the bench
// Notes:   the tick comes every fourth cycle to keep runs short
`timescale 1ns/1ps
module host_drain_model (
  input wire  clk_i, rst_i, drain_en,
  output logic base_tick_i = 0, fifo_read_i = 0
);
  logic [1:0] ph = 2'h0; // tick phase
  always @(posedge clk_i) begin
    ph <= rst_i ? 2'h0 : ph + 2'h1;
    base_tick_i <= !rst_i && ph == 2'h3;
    fifo_read_i <= !rst_i && drain_en && !fifo_read_i; // gap between reads, as a slow host
  end
endmodule // host_drain_model

//--- testbench/tb_top.sv
// Purpose: self-checking bench of the fifo control block
// Assumes: fifo depth shrunk to 16 entries
// Notes:   random pin and sample sources run outside the quiet phases
`timescale 1ns/1ps
module tb_top;
  localparam LW = 10, DEPTH = 16;
  localparam [7:0] ID = 8'h3c; // arbitrary identity value
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, quiet = 1, drain = 0;
  logic [7:0] adr_i = 0, v;
  logic [31:0] dat_i = 0, q;
  logic [11:0] r = 0; // random source levels
  wire [31:0] dat_o;
  wire [LW-1:0] fifo_level_o;
  wire ack_o, base_tick_i, fifo_read_i, fill_threshold_o, fifo_full_o, interrupt_pin_one_o;
  int num_errors = 0, total_checks = 0, n;
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) r <= quiet ? 12'h000 : 12'($urandom);
  host_drain_model u_host (.clk_i, .rst_i, .drain_en(drain), .base_tick_i, .fifo_read_i);
  sensor_fifo_batch_control #(.LW(LW), .DEPTH(DEPTH), .IDENTITY_VALUE(ID)) u_dut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hf), .dat_i, .dat_o, .ack_o,
    .base_tick_i, .stab_gyro_sample_i(r[10]), .dual_channel_i(r[8]), .psm_trigger_i(r[9]),
    .mode_trigger_i(r[11]), .fifo_read_i, .compression_master_enable_i(r[7]),
    .accel_drdy_i(r[0]), .gyro_drdy_i(r[1]), .stab_gyro_drdy_i(r[2]), .function_done_i(r[3]),
    .pin_one_function_i(r[4]), .pin_two_function_i(r[5]), .i3c_dyn_addr_i(r[6]),
    .sample_write_o(), .fifo_level_o, .fill_threshold_o, .fifo_full_o, .overrun_o(),
    .batch_counter_event_flag_o(), .compression_active_o(), .force_uncompressed_o(),
    .interrupt_pin_one_o, .interrupt_pin_two_o(), .ibi_request_o());
  task conclude;
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task bus(input [7:0] a, input w, input [7:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h00_0000, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    if (ack_o !== 1'b1) begin num_errors++; conclude; end
  endtask
  task wait_lvl(input [LW-1:0] e);
    for (n = 0; n < 3000 && fifo_level_o !== e; n++) @(posedge clk_i);
    chk(fifo_level_o, e);
    if (fifo_level_o !== e) conclude;
  endtask
  // level seen c cycles after level 1, one tick every 4 cycles, rate code halves per step down
  function int exp_lvl(input [3:0] code, input int c);
    exp_lvl = 1 + c / (4 << (12 - code));
  endfunction
  function [7:0] wmask(input [7:0] i); // reserved bits kept zero
    wmask = i == 8'h08 ? 8'hd7 : i == 8'h0b ? 8'h63 : i == 8'h0d ? 8'h7b : 8'hff;
  endfunction
  initial begin
    void'($urandom(32'h0000_1456));
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    quiet <= 0;
    for (int i = 7; i < 15; i++) begin
      bus(8'(4 * i), 0, 0);
      chk(q, 0);
      v = 8'($urandom) & wmask(8'(i));
      bus(8'(4 * i), 1, v);
      bus(8'(4 * i), 0, 0);
      chk(q, {24'h00_0000, v});
    end
    bus(8'h3c, 1, 8'hff);
    bus(8'h3c, 0, 0);
    chk(q, {24'h00_0000, ID});
    bus(8'h44, 0, 0);
    chk(q, 0);
    quiet <= 1;
    bus(8'h20, 1, 0);
    bus(8'h24, 1, 0);
    bus(8'h28, 1, 0);
    drain <= 1;
    wait_lvl(0);
    drain <= 0;
    bus(8'h40, 0, 0); // clears flags left by the random phase
    bus(8'h1c, 1, 5);
    bus(8'h34, 1, 8'h08);
    bus(8'h28, 1, 1);
    bus(8'h24, 1, 8'h0b);
    wait_lvl(1);
    repeat (60) @(posedge clk_i);
    chk(fifo_level_o, exp_lvl(4'hb, 60));
    bus(8'h24, 1, 8'h0c);
    wait_lvl(10'(DEPTH));
    chk(fifo_full_o, 1);
    chk(fill_threshold_o, 1);
    repeat (12) @(posedge clk_i);
    chk(fifo_level_o, DEPTH);
    chk(interrupt_pin_one_o, 1);
    bus(8'h40, 0, 0);
    chk(q[2:0], 3'b011);
    bus(8'h24, 1, 0);
    bus(8'h28, 1, 0);
    drain <= 1;
    wait_lvl(0);
    drain <= 0;
    bus(8'h20, 1, 8'h80);
    bus(8'h28, 1, 1);
    bus(8'h24, 1, 8'h0c);
    wait_lvl(5);
    repeat (20) @(posedge clk_i);
    chk(fifo_level_o, 5);
    bus(8'h20, 1, 0);
    bus(8'h28, 1, 8'h06);
    wait_lvl(10'(DEPTH));
    repeat (8) @(posedge clk_i);
    bus(8'h40, 0, 0);
    chk(q[2:0], 3'b111);
    conclude;
  end
endmodule // tb_top
bind sensor_fifo_batch_control fifo_batch_properties #(.LW(LW), .DEPTH(DEPTH)) u_chk (.*);
